/* File: src/err_bank_defs.vh */
/*
 Offsets, widths, field positions and reset values for the error flag bank.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef ERR_BANK_DEFS_VH
`define ERR_BANK_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define ADDR_ERROR_FLAGS     12'h001
`define ADDR_ERROR_INHIBIT   12'h01A
`define ADDR_W               12
`define DATA_W               16
`define FLAG_W               11
`define ERROR_FLAGS_RST      16'h0000
`define ERROR_INHIBIT_RST    16'h0000

// ****************************************
// Flag bit positions
// ****************************************
`define BIT_FORMAT_MISMATCH  10
`define BIT_WHOLE_FIELD      9
`define BIT_PICTURE_AREA     8
`define BIT_UNLOCK           7
`define BIT_CHROMA_SUM       6
`define BIT_LUMA_SUM         5
`define BIT_CHROMA_LINE      4
`define BIT_LUMA_LINE        3
`define BIT_LINE_INDEX       2
`define BIT_ACTIVE_START     1
`define BIT_ACTIVE_END       0

`endif

/* File: src/video_error_flag_bank.v */
/*
 Error flag bank of a serial video receiver: status flags, inhibit register,
 and active-low summary error pin.
 Assumes error detector pulses, mode levels and a simple synchronous host
 register port (address, read and write strobes) all on one clock.
*/
// Summary of operation
// - Only unlock detection works in async serial or pass-through mode.
// - Status register at 001h holds one flag per error type, set high.
// - Status clears at each field start or on host read, whichever first.
// - Standard change, unlock or slave bypass clear all but unlock flag; reset clears all flags.
// - Inhibit register at 01Ah has one bit per flag, same positions.
// - Inhibit resets to zero; host writes a bit high to disable that error.
// - Summary pin is high idle, low while any flag is set.
// - Bit 10 sets when payload identifier disagrees with computed standard.
// - In SD, bit 9 on full-field CRC error, bit 8 on picture-area CRC error.
// - Bit 7 stays high while lock indication is low.
// - Bit 6 on chroma ancillary checksum error, bit 5 on luma one.
// - In HD, bit 4 on chroma line CRC error, bit 3 on luma one.
// - In HD, bit 2 on received line number mismatch.
// - Bit 1 on start code errors, bit 0 on end code errors, both widths.
// - Code checks need flywheel on and, in HD, use luma codes only.
// - Rate select low means HD, high means SD.
`include "err_bank_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module video_error_flag_bank (
	input  wire                 clock,
	input  wire                 rst_n,
	input  wire [`ADDR_W-1:0]   host_addr,
	input  wire                 host_rd,
	input  wire                 host_wr,
	input  wire [`DATA_W-1:0]   host_wdata,
	output reg  [`DATA_W-1:0]   host_rdata,
	input  wire                 async_serial_mode,
	input  wire                 pass_through_mode,
	input  wire                 slave_mode,
	input  wire                 processing_on,
	input  wire                 rate_select,
	input  wire                 flywheel_on,
	input  wire                 lock_in,
	input  wire                 field_start,
	input  wire                 standard_change,
	input  wire                 format_mismatch_evt,
	input  wire                 whole_field_crc_evt,
	input  wire                 picture_area_crc_evt,
	input  wire                 chroma_sum_evt,
	input  wire                 luma_sum_evt,
	input  wire                 chroma_line_crc_evt,
	input  wire                 luma_line_crc_evt,
	input  wire                 line_index_evt,
	input  wire                 start_code_luma_evt,
	input  wire                 start_code_chroma_evt,
	input  wire                 end_code_luma_evt,
	input  wire                 end_code_chroma_evt,
	output wire                 error_n
);

	// ****************************************
	// Reset synchroniser
	// ****************************************
	reg                     rst_meta_r;
	reg                     rst_sync_r;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ****************************************
	// Detector gating
	// ****************************************
	wire                    smpte_on;
	wire                    sd_mode;
	wire                    hd_mode;
	wire                    code_chk;
	wire                    start_code_evt;
	wire                    end_code_evt;
	reg  [`FLAG_W-1:0]      raw_evt;
	reg  [`FLAG_W-1:0]      inhibit_r;
	wire [`FLAG_W-1:0]      set_vec;

	assign smpte_on = !async_serial_mode && !pass_through_mode;
	assign sd_mode  = rate_select;
	assign hd_mode  = !rate_select;
	assign code_chk = smpte_on && flywheel_on;
	assign start_code_evt = start_code_luma_evt || (sd_mode && start_code_chroma_evt);
	assign end_code_evt   = end_code_luma_evt || (sd_mode && end_code_chroma_evt);

	always @* begin
		raw_evt = {`FLAG_W{1'b0}};
		raw_evt[`BIT_FORMAT_MISMATCH] = smpte_on && format_mismatch_evt;
		raw_evt[`BIT_WHOLE_FIELD]  = smpte_on && sd_mode && whole_field_crc_evt;
		raw_evt[`BIT_PICTURE_AREA] = smpte_on && sd_mode && picture_area_crc_evt;
		raw_evt[`BIT_UNLOCK]       = !lock_in;
		raw_evt[`BIT_CHROMA_SUM]   = smpte_on && chroma_sum_evt;
		raw_evt[`BIT_LUMA_SUM]     = smpte_on && luma_sum_evt;
		raw_evt[`BIT_CHROMA_LINE]  = smpte_on && hd_mode && chroma_line_crc_evt;
		raw_evt[`BIT_LUMA_LINE]    = smpte_on && hd_mode && luma_line_crc_evt;
		raw_evt[`BIT_LINE_INDEX]   = smpte_on && hd_mode && line_index_evt;
		raw_evt[`BIT_ACTIVE_START] = code_chk && start_code_evt;
		raw_evt[`BIT_ACTIVE_END]   = code_chk && end_code_evt;
	end

	assign set_vec = raw_evt & ~inhibit_r;

	// ****************************************
	// Clear sources
	// ****************************************
	wire                    rd_flags;
	wire                    rd_inhibit;
	wire                    wr_inhibit;
	wire                    clr_all;
	wire                    clr_hold;
	wire [`FLAG_W-1:0]      clr_vec;

	assign rd_flags   = host_rd && (host_addr == `ADDR_ERROR_FLAGS);
	assign rd_inhibit = host_rd && (host_addr == `ADDR_ERROR_INHIBIT);
	assign wr_inhibit = host_wr && (host_addr == `ADDR_ERROR_INHIBIT);
	assign clr_all    = field_start || rd_flags;
	assign clr_hold   = standard_change || !lock_in || (slave_mode && !processing_on);

	genvar gi;
	generate
		for (gi = 0; gi < `FLAG_W; gi = gi + 1) begin : g_clr
			if (gi == `BIT_UNLOCK) begin : g_unlock
				assign clr_vec[gi] = clr_all;
			end else begin : g_other
				assign clr_vec[gi] = clr_all || clr_hold;
			end
		end
	endgenerate

	// ****************************************
	// Status and inhibit registers
	// ****************************************
	reg  [`FLAG_W-1:0]      flags_r;
	wire [`FLAG_W-1:0]      flags_nxt;
	wire [`DATA_W-1:0]      flags_rst_w;
	wire [`DATA_W-1:0]      inhibit_rst_w;

	assign flags_rst_w   = `ERROR_FLAGS_RST;
	assign inhibit_rst_w = `ERROR_INHIBIT_RST;

	assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

	always @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			flags_r   <= flags_rst_w[`FLAG_W-1:0];
			inhibit_r <= inhibit_rst_w[`FLAG_W-1:0];
		end else begin
			flags_r <= flags_nxt;
			if (wr_inhibit) begin
				inhibit_r <= host_wdata[`FLAG_W-1:0];
			end
		end
	end

	// ****************************************
	// Host read data
	// ****************************************
	always @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			host_rdata <= 16'h0000;
		end else if (rd_flags) begin
			host_rdata <= {{(`DATA_W-`FLAG_W){1'b0}}, flags_r};
		end else if (rd_inhibit) begin
			host_rdata <= {{(`DATA_W-`FLAG_W){1'b0}}, inhibit_r};
		end else if (host_rd) begin
			host_rdata <= 16'h0000;
		end
	end

	// ****************************************
	// Summary error pin
	// ****************************************
	assign error_n = ~(|flags_r);

endmodule

`default_nettype wire

/* File: bench/err_bank_props.sv */
/* Port assertions for the error flag bank. Assumes a bind onto the top module. */
`timescale 1ns/100ps
`default_nettype none
module err_bank_props (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [11:0] host_addr,
	input wire logic        host_rd,
	input wire logic [15:0] host_rdata,
	input wire logic        async_serial_mode,
	input wire logic        pass_through_mode,
	input wire logic        lock_in,
	input wire logic        field_start,
	input wire logic        chroma_sum_evt,
	input wire logic        error_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic rd_f = host_rd && host_addr == 12'h001;
	AST_UNLOCK: assert property (!lock_in |=> !error_n) else $error("unlock not flagged");
	AST_SET: assert property (chroma_sum_evt && lock_in && !async_serial_mode &&
		!pass_through_mode |=> !error_n) else $error("event not flagged");
	AST_OFF: assert property ((async_serial_mode || pass_through_mode) && lock_in && error_n
		|=> error_n) else $error("detector active in off mode");
	AST_FIELD: assert property (field_start && lock_in && !chroma_sum_evt |=> error_n)
		else $error("field start kept flags");
	AST_RDCLR: assert property (rd_f && lock_in && !chroma_sum_evt |=> error_n)
		else $error("read kept flags");
	AST_RDVAL: assert property (rd_f && !error_n |=> host_rdata[10:0] != 11'h000)
		else $error("read lost flags");
	AST_UNMAP: assert property (host_rd && host_addr != 12'h001 && host_addr != 12'h01A
		|=> host_rdata == 16'h0000) else $error("unmapped read not zero");
	AST_TOP: assert property (host_rd |=> host_rdata[15:11] == 5'h00)
		else $error("unused bits set");
endmodule
bind video_error_flag_bank err_bank_props u_err_bank_props (.*);
`default_nettype wire

/* File: bench/host_port_model.sv */
/* Host side of the register port. Assumes the bench clock. */
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
	input  wire logic        clock,
	output logic      [11:0] host_addr,
	output logic             host_rd,
	output logic             host_wr,
	output logic      [15:0] host_wdata,
	input  wire logic [15:0] host_rdata
);
	initial {host_addr, host_rd, host_wr, host_wdata} = 30'h0000_0000;
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		@(negedge clock);
		{host_addr, host_rd} = {a, 1'b1};
		@(negedge clock);
		{host_addr, host_rd} = {~a, 1'b0};
		d = host_rdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(negedge clock);
		{host_addr, host_wdata, host_wr} = {a, d, 1'b1};
		@(negedge clock);
		{host_addr, host_wdata, host_wr} = {~a, ~d, 1'b0};
	endtask
endmodule
`default_nettype wire

/* File: bench/video_error_flag_bank_test.sv */
/* Self-checking bench for the error flag bank. Assumes the host port model. */
`timescale 1ns/100ps
`default_nettype none
module video_error_flag_bank_test;
	logic        clock, rst_n, async_serial_mode, pass_through_mode, slave_mode, error_n;
	logic        processing_on, rate_select, flywheel_on, lock_in, field_start, standard_change;
	logic        host_rd, host_wr;
	logic [11:0] host_addr, ev;
	logic [15:0] host_wdata, host_rdata, d, x;
	int          bad_count, cmp_count;
	int          pos[12] = '{0, 0, 1, 1, 2, 3, 4, 5, 6, 8, 9, 10};
	video_error_flag_bank u_video_error_flag_bank (.clock, .rst_n, .host_addr, .host_rd,
		.host_wr, .host_wdata, .host_rdata, .async_serial_mode, .pass_through_mode,
		.slave_mode, .processing_on, .rate_select, .flywheel_on, .lock_in, .field_start,
		.standard_change, .format_mismatch_evt(ev[11]), .whole_field_crc_evt(ev[10]),
		.picture_area_crc_evt(ev[9]), .chroma_sum_evt(ev[8]), .luma_sum_evt(ev[7]),
		.chroma_line_crc_evt(ev[6]), .luma_line_crc_evt(ev[5]), .line_index_evt(ev[4]),
		.start_code_luma_evt(ev[3]), .start_code_chroma_evt(ev[2]),
		.end_code_luma_evt(ev[1]), .end_code_chroma_evt(ev[0]), .error_n);
	host_port_model u_host_port_model (.clock, .host_addr, .host_rd, .host_wr, .host_wdata,
		.host_rdata);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
		u_host_port_model.rd(a, d);
		check(d, exp);
	endtask
	task automatic pulse(input logic [11:0] e);
		@(negedge clock);
		ev = e;
		@(negedge clock);
		ev = 12'h000;
	endtask
	task automatic t_events();
		rdchk(12'h01A, 16'h0000);
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 12; i++) begin
				rate_select = s[0];
				x = ((s ? 12'h070 : 12'h605) >> i) & 12'h001 ? 16'h0000 : 16'h0001 << pos[i];
				pulse(12'h001 << i);
				check({15'h0000, error_n}, {15'h0000, x == 16'h0000});
				rdchk(12'h001, x);
				rdchk(12'h001, 16'h0000);
			end
		end
		flywheel_on = 1'b0;
		pulse(12'h00F);
		rdchk(12'h001, 16'h0000);
		flywheel_on = 1'b1;
		$display("events test done");
	endtask
	task automatic t_inhibit();
		u_host_port_model.wr(12'h01A, 16'hFFBF);
		u_host_port_model.wr(12'h001, 16'hFFFF);
		rdchk(12'h01A, 16'h07BF);
		pulse(12'hFFF);
		rdchk(12'h001, 16'h0040);
		rdchk(12'h0FF, 16'h0000);
		u_host_port_model.wr(12'h01A, 16'h0000);
		$display("inhibit test done");
	endtask
	task automatic t_modes();
		for (int m = 1; m < 3; m++) begin
			{async_serial_mode, pass_through_mode} = m[1:0];
			pulse(12'hFFF);
			rdchk(12'h001, 16'h0000);
			lock_in = 1'b0;
			pulse(12'h000);
			rdchk(12'h001, 16'h0080);
			rdchk(12'h001, 16'h0080);
			lock_in = 1'b1;
			rdchk(12'h001, 16'h0080);
			rdchk(12'h001, 16'h0000);
		end
		{async_serial_mode, pass_through_mode, slave_mode} = 3'b001;
		for (int k = 0; k < 3; k++) begin
			pulse(12'h100);
			{field_start, standard_change, processing_on} = k == 0 ? 3'b101 : k == 1 ? 3'b011 : 3'b000;
			@(negedge clock);
			{field_start, standard_change, processing_on} = 3'b001;
			rdchk(12'h001, 16'h0000);
		end
		lock_in = 1'b0;
		pulse(12'h100);
		rdchk(12'h001, 16'h0080);
		lock_in = 1'b1;
		rdchk(12'h001, 16'h0080);
		rdchk(12'h001, 16'h0000);
		$display("modes test done");
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{rst_n, ev, async_serial_mode, pass_through_mode, slave_mode} = 16'h0000;
		{processing_on, rate_select, flywheel_on, lock_in, field_start, standard_change} = 6'h2C;
		{bad_count, cmp_count} = 64'h0000_0000_0000_0000;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		t_events();
		t_inhibit();
		t_modes();
		report_and_stop();
	end
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
